// ---- verilog/sequencer_pkg.sv ----
// Shared constants, types and functional notes for the machine cycle sequencer.
// Functional notes
// - Group printing: first card group-indicates at 100.
// - Group indicate prints identity from first card.
// - Total cycle rotates counters, zero stops type.
// - Printed program totals run at 100 per minute.
// - Conversion at 150 only if option fitted.
// - Summary punch cycle: no feed, punch reads.
// - Program unit runs panel-wired operation sequence.
// - Program unit issues counter source impulses.
// - Listing or total printing may be postponed.
// - Conversion, punching, skipping happen in idle cycles.
// - Motor on, no clutch magnet means idling.
// - List, indicate, printed total run 80 or 100.
// - Non-print drops printing, returns to 150.
// - Non-list, conversion, punching, skipping run 150.
// - Breaker groups follow cycle type table.
// - Non-print wired keeps print clutch disengaged.
// - List picker knife may follow control punching.
// - Cycle is 360 degrees, 20 points of 18.
// - Cycles start at 330 degrees feed engagement.
// - Non-list keeps type bars at rest, 150.
package sequencer_pkg;
	localparam longint unsigned CLK_HZ = 64'd125_000_000;
	localparam longint unsigned SEC_PER_MIN = 64'd60;
	localparam int unsigned DEG_PER_CYCLE = 360;
	localparam int unsigned POINTS_PER_CYCLE = 20;
	localparam int unsigned DEG_PER_POINT = 18;
	localparam logic [8:0] FEED_ENGAGE_DEG = 9'h14A;
	localparam logic [8:0] LAST_DEG = 9'h167;
	localparam longint unsigned SPEED_SLOW_CPM = 64'd80;
	localparam longint unsigned SPEED_PRINT_CPM = 64'd100;
	localparam longint unsigned SPEED_FAST_CPM = 64'd150;
	localparam longint unsigned DEG_TICKS_SLOW =
		(CLK_HZ * SEC_PER_MIN) / (SPEED_SLOW_CPM * DEG_PER_CYCLE);
	localparam longint unsigned DEG_TICKS_PRINT =
		(CLK_HZ * SEC_PER_MIN) / (SPEED_PRINT_CPM * DEG_PER_CYCLE);
	localparam longint unsigned DEG_TICKS_FAST =
		(CLK_HZ * SEC_PER_MIN) / (SPEED_FAST_CPM * DEG_PER_CYCLE);
	localparam int COUNTERS = 8;
	localparam int PROG_STEPS = 4;
	localparam int OP_W = 3;
	localparam int DELAY_W = 2;
	localparam logic [DELAY_W-1:0] DELAY_RESET = 2'h0;
	localparam logic [1:0] STEP_RESET = 2'h0;

	typedef enum logic [1:0] {
		ST_IDLING = 2'h1,
		ST_RUNNING = 2'h2
	} seq_state_type;

	typedef enum logic [6:0] {
		CYC_LIST = 7'h01,
		CYC_NON_LIST = 7'h02,
		CYC_GROUP_IND = 7'h04,
		CYC_PROG_TOTAL = 7'h08,
		CYC_CONVERSION = 7'h10,
		CYC_SUMMARY = 7'h20,
		CYC_IDLE = 7'h40
	} cycle_kind_type;

	typedef enum logic [2:0] {
		SPD_SLOW = 3'h1,
		SPD_PRINT = 3'h2,
		SPD_FAST = 3'h4
	} speed_type;

	typedef struct packed {
		logic motor_running;
		logic list_wired;
		logic group_print;
		logic group_change;
		logic total_print;
		logic non_print;
		logic negative_balance_fitted;
		logic conversion_request;
		logic summary_request;
		logic carriage_skip;
		logic card_available;
		logic slow_speed;
		logic multi_line;
		logic picker_punch;
		logic program_enable;
		logic [DELAY_W-1:0] list_delay;
		logic [DELAY_W-1:0] total_delay;
	} panel_type;

	typedef struct packed {
		logic print_cycle_breakers;
		logic continuous_breakers;
		logic feed_cycle_breakers;
	} breakers_type;

	typedef struct packed {
		logic high_speed_magnet;
		logic low_speed_magnet;
		logic card_feed_clutch;
		logic picker_knife_clutch;
		logic print_clutch;
	} clutches_type;
endpackage : sequencer_pkg

// ---- verilog/machine_index_timer.sv ----
// Machine index timer: degrees, cycle points and end of cycle.
`timescale 1ns/1ns
`default_nettype none
module machine_index_timer (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic run_in,
	input wire logic [31:0] deg_ticks_in,
	output logic [8:0] degree_out,
	output logic [4:0] point_out,
	output logic cycle_done_out
);
	logic [31:0] tick_reg;
	logic [31:0] tick_next;
	logic [8:0] degree_reg;
	logic [8:0] degree_next;
	logic [8:0] pt_deg_reg;
	logic [8:0] pt_deg_next;
	logic [4:0] point_reg;
	logic [4:0] point_next;
	logic done_reg;
	wire deg_step = run_in && (tick_reg >= deg_ticks_in - 32'h1);
	wire deg_wrap = degree_reg == sequencer_pkg::LAST_DEG;
	wire pt_step = pt_deg_reg == 9'(sequencer_pkg::DEG_PER_POINT - 1);
	wire pt_wrap = point_reg == 5'(sequencer_pkg::POINTS_PER_CYCLE - 1);

	// The index rests at feed engagement so every cycle starts there.
	assign tick_next = (!run_in || deg_step) ? 32'h0 : tick_reg + 32'h1;
	assign degree_next = !deg_step ? degree_reg : deg_wrap ? 9'h0 : degree_reg + 9'h1;
	assign pt_deg_next = !deg_step ? pt_deg_reg : pt_step ? 9'h0 : pt_deg_reg + 9'h1;
	assign point_next = !(deg_step && pt_step) ? point_reg :
		pt_wrap ? 5'h0 : point_reg + 5'h1;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			tick_reg <= 32'h0;
			degree_reg <= sequencer_pkg::FEED_ENGAGE_DEG;
			pt_deg_reg <= 9'h6;
			point_reg <= 5'h12;
			done_reg <= 1'b0;
		end else begin
			tick_reg <= tick_next;
			degree_reg <= degree_next;
			pt_deg_reg <= pt_deg_next;
			point_reg <= point_next;
			done_reg <= deg_step && degree_next == sequencer_pkg::FEED_ENGAGE_DEG;
		end
	end

	assign degree_out = degree_reg;
	assign point_out = point_reg;
	assign cycle_done_out = done_reg;
endmodule : machine_index_timer
`default_nettype wire

// ---- verilog/machine_cycle_sequencer.sv ----
// Machine cycle sequencer: picks each cycle's type, speed, breakers and clutches.
`timescale 1ns/1ns
`default_nettype none
module machine_cycle_sequencer #(
	parameter int unsigned DEG_TICKS_SLOW = 32'(sequencer_pkg::DEG_TICKS_SLOW),
	parameter int unsigned DEG_TICKS_PRINT = 32'(sequencer_pkg::DEG_TICKS_PRINT),
	parameter int unsigned DEG_TICKS_FAST = 32'(sequencer_pkg::DEG_TICKS_FAST)
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire sequencer_pkg::panel_type panel_in,
	input wire logic [sequencer_pkg::COUNTERS-1:0] counter_zero_in,
	input wire logic [sequencer_pkg::PROG_STEPS*sequencer_pkg::OP_W-1:0] program_ops_in,
	output sequencer_pkg::cycle_kind_type cycle_kind_out,
	output sequencer_pkg::speed_type speed_out,
	output sequencer_pkg::breakers_type breakers_out,
	output sequencer_pkg::clutches_type clutches_out,
	output logic cycle_active_out,
	output logic idle_cycle_out,
	output logic idling_out,
	output logic type_bars_active_out,
	output logic print_from_card_out,
	output logic counter_rotate_out,
	output logic [sequencer_pkg::COUNTERS-1:0] type_stop_out,
	output logic punch_read_out,
	output logic [sequencer_pkg::OP_W-1:0] source_impulse_out,
	output logic [8:0] degree_out,
	output logic [4:0] point_out
);
	localparam int PW = $bits(sequencer_pkg::panel_type);
	localparam int SW = PW + sequencer_pkg::COUNTERS;

	// Every panel_in field and counter pin passes two flops before any logic reads it; program_ops_in is read directly.
	logic [SW-1:0] sync1_reg;
	logic [SW-1:0] sync2_reg;
	// Counter levels sit above the panel fields so each sync bit has one pin to copy.
	wire [SW-1:0] pins = {counter_zero_in, panel_in};
	genvar gi;
	generate
		for (gi = 0; gi < SW; gi++) begin : g_sync
			always_ff @(posedge clk_in) begin
				if (rst_in) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end else begin
					sync1_reg[gi] <= pins[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	sequencer_pkg::panel_type pnl;
	wire [sequencer_pkg::COUNTERS-1:0] zero_s = sync2_reg[SW-1:PW];
	assign pnl = sync2_reg[PW-1:0];

	sequencer_pkg::seq_state_type state_reg;
	sequencer_pkg::seq_state_type state_next;
	sequencer_pkg::cycle_kind_type kind_reg;
	sequencer_pkg::cycle_kind_type kind_next;
	sequencer_pkg::speed_type speed_reg;
	sequencer_pkg::speed_type speed_next;
	logic nonprint_reg;
	logic picker_reg;
	logic first_reg;
	logic first_next;
	logic total_pend_reg;
	logic total_pend_next;
	logic [sequencer_pkg::DELAY_W-1:0] total_wait_reg;
	logic [sequencer_pkg::DELAY_W-1:0] total_wait_next;
	logic [sequencer_pkg::DELAY_W-1:0] list_wait_reg;
	logic [sequencer_pkg::DELAY_W-1:0] list_wait_next;
	logic [1:0] step_reg;
	logic [1:0] step_next;
	logic [sequencer_pkg::OP_W-1:0] impulse_reg;
	logic [sequencer_pkg::COUNTERS-1:0] zero_prev_reg;
	logic [sequencer_pkg::COUNTERS-1:0] stop_reg;
	logic cycle_done;
	logic [31:0] deg_ticks;

	wire running = state_reg == sequencer_pkg::ST_RUNNING;
	wire decide = (state_reg == sequencer_pkg::ST_IDLING) || cycle_done;
	wire grp_start = pnl.group_change && !total_pend_reg;
	wire conv_ok = pnl.conversion_request && pnl.negative_balance_fitted;
	wire total_due = total_pend_reg && total_wait_reg == sequencer_pkg::DELAY_RESET;
	wire list_due = list_wait_reg == sequencer_pkg::DELAY_RESET;
	wire card_go = pnl.card_available && !total_pend_reg && !grp_start;
	wire want = pnl.motor_running && (pnl.summary_request || conv_ok ||
		total_pend_reg || grp_start || pnl.carriage_skip || pnl.card_available);

	// Priority: punching, conversion, due total, card, else an idle cycle.
	assign kind_next =
		pnl.summary_request ? sequencer_pkg::CYC_SUMMARY :
		conv_ok ? sequencer_pkg::CYC_CONVERSION :
		total_due ? sequencer_pkg::CYC_PROG_TOTAL :
		(card_go && first_reg && pnl.group_print) ? sequencer_pkg::CYC_GROUP_IND :
		(card_go && pnl.list_wired && list_due) ? sequencer_pkg::CYC_LIST :
		card_go ? sequencer_pkg::CYC_NON_LIST :
		sequencer_pkg::CYC_IDLE;

	wire prints = kind_next == sequencer_pkg::CYC_LIST
		|| kind_next == sequencer_pkg::CYC_GROUP_IND
		|| (kind_next == sequencer_pkg::CYC_PROG_TOTAL && pnl.total_print);
	assign speed_next = (!prints || pnl.non_print) ? sequencer_pkg::SPD_FAST :
		(pnl.slow_speed && kind_next == sequencer_pkg::CYC_LIST) ?
		sequencer_pkg::SPD_SLOW : sequencer_pkg::SPD_PRINT;
	assign state_next = want ? sequencer_pkg::ST_RUNNING : sequencer_pkg::ST_IDLING;

	// A group change raises a total, postponed by the wired delay.
	assign total_pend_next = grp_start ? 1'b1 :
		(kind_next == sequencer_pkg::CYC_PROG_TOTAL) ? 1'b0 : total_pend_reg;
	assign total_wait_next = grp_start ? pnl.total_delay :
		(total_pend_reg && !total_due) ? total_wait_reg - 2'h1 : total_wait_reg;
	assign first_next = grp_start ? 1'b1 :
		(kind_next == sequencer_pkg::CYC_GROUP_IND) ? 1'b0 : first_reg;
	assign list_wait_next = grp_start ? pnl.list_delay :
		(card_go && !list_due) ? list_wait_reg - 2'h1 : list_wait_reg;
	// The program walks the wired steps in fixed order, one per decision: each cycle end, or each clock while idling.
	assign step_next = (pnl.program_enable && !grp_start) ? step_reg + 2'h1 : 2'h0;

	assign deg_ticks = (speed_reg == sequencer_pkg::SPD_SLOW) ? DEG_TICKS_SLOW :
		(speed_reg == sequencer_pkg::SPD_PRINT) ? DEG_TICKS_PRINT : DEG_TICKS_FAST;

	machine_index_timer u_index (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.run_in(running),
		.deg_ticks_in(deg_ticks),
		.degree_out(degree_out),
		.point_out(point_out),
		.cycle_done_out(cycle_done)
	);

	// Selection is latched only at a boundary and held for the whole cycle.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg <= sequencer_pkg::ST_IDLING;
			kind_reg <= sequencer_pkg::CYC_IDLE;
			speed_reg <= sequencer_pkg::SPD_FAST;
			nonprint_reg <= 1'b0;
			picker_reg <= 1'b0;
			first_reg <= 1'b1;
			total_pend_reg <= 1'b0;
			total_wait_reg <= sequencer_pkg::DELAY_RESET;
			list_wait_reg <= sequencer_pkg::DELAY_RESET;
			step_reg <= sequencer_pkg::STEP_RESET;
			impulse_reg <= '0;
		end else if (decide) begin
			state_reg <= state_next;
			kind_reg <= kind_next;
			speed_reg <= speed_next;
			nonprint_reg <= pnl.non_print;
			picker_reg <= !pnl.multi_line || pnl.picker_punch;
			first_reg <= first_next;
			total_pend_reg <= total_pend_next;
			total_wait_reg <= total_wait_next;
			list_wait_reg <= list_wait_next;
			step_reg <= step_next;
			impulse_reg <= (want && pnl.program_enable) ?
				program_ops_in[step_reg*sequencer_pkg::OP_W +: sequencer_pkg::OP_W] :
				'0;
		end else begin
			impulse_reg <= '0;
		end
	end

	// A counter arriving at zero stops its type bar on a printed total.
	wire total_print_cyc = running && kind_reg == sequencer_pkg::CYC_PROG_TOTAL
		&& speed_reg != sequencer_pkg::SPD_FAST;
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			zero_prev_reg <= '0;
			stop_reg <= '0;
		end else begin
			zero_prev_reg <= zero_s;
			stop_reg <= total_print_cyc ? (zero_s & ~zero_prev_reg) : '0;
		end
	end

	wire k_list = kind_reg == sequencer_pkg::CYC_LIST;
	wire k_gi = kind_reg == sequencer_pkg::CYC_GROUP_IND;
	wire k_nl = kind_reg == sequencer_pkg::CYC_NON_LIST;
	wire k_pt = kind_reg == sequencer_pkg::CYC_PROG_TOTAL;
	wire k_idle = kind_reg == sequencer_pkg::CYC_CONVERSION
		|| kind_reg == sequencer_pkg::CYC_SUMMARY || kind_reg == sequencer_pkg::CYC_IDLE;
	wire feed_cyc = running && (k_list || k_gi || k_nl);
	wire print_cyc = running && (k_list || k_gi || k_pt) && !nonprint_reg;

	assign breakers_out.print_cycle_breakers = print_cyc;
	assign breakers_out.continuous_breakers = running;
	assign breakers_out.feed_cycle_breakers = feed_cyc;
	assign clutches_out.high_speed_magnet = running && speed_reg == sequencer_pkg::SPD_FAST;
	assign clutches_out.low_speed_magnet = running && speed_reg != sequencer_pkg::SPD_FAST;
	assign clutches_out.card_feed_clutch = feed_cyc;
	assign clutches_out.picker_knife_clutch = feed_cyc && (!k_list || picker_reg);
	assign clutches_out.print_clutch = print_cyc;
	assign cycle_kind_out = kind_reg;
	assign speed_out = speed_reg;
	assign cycle_active_out = running;
	assign idle_cycle_out = running && k_idle;
	assign idling_out = pnl.motor_running && !running;
	assign type_bars_active_out = print_cyc;
	assign print_from_card_out = print_cyc && k_gi;
	assign counter_rotate_out = running && k_pt;
	assign type_stop_out = stop_reg;
	assign punch_read_out = running && kind_reg == sequencer_pkg::CYC_SUMMARY;
	assign source_impulse_out = impulse_reg;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence s_cycle_end;
		cycle_done && running;
	endsequence
	sequence s_kind_hold;
		$stable(kind_reg) && $stable(speed_reg);
	endsequence

	property p_hold;
		running && !cycle_done |=> s_kind_hold;
	endproperty
	a_hold: assert property (p_hold) else $error("Cycle selection changed mid cycle.");
	property p_nonprint;
		running && nonprint_reg |-> !clutches_out.print_clutch && speed_reg == sequencer_pkg::SPD_FAST;
	endproperty
	a_nonprint: assert property (p_nonprint) else $error("Print ran with non-print.");
	property p_summary;
		punch_read_out |-> !clutches_out.card_feed_clutch && !breakers_out.print_cycle_breakers;
	endproperty
	a_summary: assert property (p_summary) else $error("Feed or print on punch cycle.");
	property p_conv;
		running && kind_reg == sequencer_pkg::CYC_CONVERSION |-> speed_reg == sequencer_pkg::SPD_FAST
			&& !breakers_out.print_cycle_breakers && !breakers_out.feed_cycle_breakers;
	endproperty
	a_conv: assert property (p_conv) else $error("Conversion cycle misrun.");
	property p_gi_speed;
		running && k_gi && !nonprint_reg |-> speed_reg == sequencer_pkg::SPD_PRINT;
	endproperty
	a_gi_speed: assert property (p_gi_speed) else $error("Group indicate not at 100.");
	property p_nl;
		running && k_nl |-> speed_reg == sequencer_pkg::SPD_FAST && !type_bars_active_out
			&& breakers_out.feed_cycle_breakers;
	endproperty
	a_nl: assert property (p_nl) else $error("Non-list cycle misrun.");
	property p_idle;
		idle_cycle_out |-> clutches_out.high_speed_magnet && !clutches_out.card_feed_clutch
			&& !clutches_out.print_clutch;
	endproperty
	a_idle: assert property (p_idle) else $error("Idle cycle drove feed or print.");
	property p_idling;
		idling_out |-> !clutches_out.high_speed_magnet && !clutches_out.low_speed_magnet;
	endproperty
	a_idling: assert property (p_idling) else $error("Magnet on while idling.");
	property p_start;
		s_cycle_end |-> degree_out == sequencer_pkg::FEED_ENGAGE_DEG;
	endproperty
	a_start: assert property (p_start) else $error("Cycle did not end at feed engage.");
	property p_breakers;
		running && k_pt |-> !breakers_out.feed_cycle_breakers && breakers_out.continuous_breakers;
	endproperty
	a_breakers: assert property (p_breakers) else $error("Total cycle breakers wrong.");
endmodule : machine_cycle_sequencer
`default_nettype wire

// ---- tb/panel_punch_model.sv ----
// Model of the control panel wiring, the counter wheels and the attached summary punch.
`timescale 1ns/1ns
`default_nettype none
module panel_punch_model #(
	parameter int ZERO_STEP = 6
) (
	input wire logic clk_in,
	input wire sequencer_pkg::panel_type setting_in,
	input wire logic counter_rotate_in,
	input wire logic punch_read_in,
	output sequencer_pkg::panel_type panel_out,
	output logic [sequencer_pkg::COUNTERS-1:0] counter_zero_out,
	output logic punch_done_out
);
	int rot_cnt = 0;

	initial begin
		panel_out = '0;
		counter_zero_out = '0;
		punch_done_out = 1'b0;
	end

	// Counters reach zero one after another, so each type stop must follow its own counter.
	always @(posedge clk_in) begin
		panel_out <= setting_in;
		if (counter_rotate_in) begin
			rot_cnt <= rot_cnt + 1;
		end else begin
			rot_cnt <= 0;
		end
		for (int k = 0; k < sequencer_pkg::COUNTERS; k++) begin
			counter_zero_out[k] <= counter_rotate_in && (rot_cnt >= 10 + ZERO_STEP * k);
		end
		if (punch_read_in) begin
			punch_done_out <= 1'b1;
		end
	end
endmodule : panel_punch_model
`default_nettype wire

// ---- tb/tb_machine_cycle_sequencer.sv ----
// Self-checking testbench for the machine cycle sequencer.
`timescale 1ns/1ns
`default_nettype none
module tb_machine_cycle_sequencer;
	localparam logic [18:0] MOT = 19'h40000;
	localparam logic [18:0] LST = 19'h20000;
	localparam logic [18:0] GRP = 19'h10000;
	localparam logic [18:0] GCH = 19'h08000;
	localparam logic [18:0] TOT = 19'h04000;
	localparam logic [18:0] NPR = 19'h02000;
	localparam logic [18:0] NEG = 19'h01000;
	localparam logic [18:0] CNV = 19'h00800;
	localparam logic [18:0] SUM = 19'h00400;
	localparam logic [18:0] SKP = 19'h00200;
	localparam logic [18:0] CRD = 19'h00100;
	localparam logic [18:0] SLO = 19'h00080;
	localparam logic [18:0] PEN = 19'h00010;
	localparam logic [18:0] MUL = 19'h00040;
	typedef struct {
		logic [18:0] pnl;
		logic [6:0] kind;
		logic [2:0] spd;
		logic [2:0] brk;
		logic [2:0] fpi;
	} row_type;
	row_type rows [8] = '{
		'{MOT | LST | CRD, 7'h01, 3'h2, 3'h7, 3'h6},
		'{MOT | LST | CRD | SLO, 7'h01, 3'h1, 3'h7, 3'h6},
		'{MOT | CRD, 7'h02, 3'h4, 3'h3, 3'h4},
		'{MOT | LST | CRD | NPR, 7'h01, 3'h4, 3'h3, 3'h4},
		'{MOT | NEG | CNV, 7'h10, 3'h4, 3'h2, 3'h1},
		'{MOT | CNV | CRD, 7'h02, 3'h4, 3'h3, 3'h4},
		'{MOT | SUM, 7'h20, 3'h4, 3'h2, 3'h1},
		'{MOT | SKP, 7'h40, 3'h4, 3'h2, 3'h1}
	};
	logic clk_in;
	logic rst_in = 1'b1;
	sequencer_pkg::panel_type setting = '0;
	sequencer_pkg::panel_type panel;
	logic [7:0] zero;
	logic [11:0] ops = 12'h000;
	sequencer_pkg::cycle_kind_type cycle_kind_out;
	sequencer_pkg::speed_type speed_out;
	sequencer_pkg::breakers_type breakers_out;
	sequencer_pkg::clutches_type clutches_out;
	logic cycle_active_out, idle_cycle_out, idling_out, type_bars_active_out;
	logic print_from_card_out, counter_rotate_out, punch_read_out, punch_done;
	logic [7:0] type_stop_out;
	logic [2:0] source_impulse_out;
	logic [2:0] last_op;
	logic [2:0] prev;
	logic [8:0] degree_out;
	logic [4:0] point_out;
	int fails = 0;
	int tests_run = 0;
	int stop_cnt = 0;
	int p0, p1;

	// Short degree periods keep a whole cycle near a thousand clocks.
	machine_cycle_sequencer #(.DEG_TICKS_SLOW(4), .DEG_TICKS_PRINT(3), .DEG_TICKS_FAST(2)) u_dut (
		.clk_in(clk_in), .rst_in(rst_in), .panel_in(panel), .counter_zero_in(zero),
		.program_ops_in(ops), .cycle_kind_out(cycle_kind_out), .speed_out(speed_out),
		.breakers_out(breakers_out), .clutches_out(clutches_out),
		.cycle_active_out(cycle_active_out), .idle_cycle_out(idle_cycle_out),
		.idling_out(idling_out), .type_bars_active_out(type_bars_active_out),
		.print_from_card_out(print_from_card_out), .counter_rotate_out(counter_rotate_out),
		.type_stop_out(type_stop_out), .punch_read_out(punch_read_out),
		.source_impulse_out(source_impulse_out), .degree_out(degree_out), .point_out(point_out)
	);
	panel_punch_model u_model (
		.clk_in(clk_in), .setting_in(setting), .counter_rotate_in(counter_rotate_out),
		.punch_read_in(punch_read_out), .panel_out(panel), .counter_zero_out(zero),
		.punch_done_out(punch_done)
	);

	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		stop_cnt <= stop_cnt + $countones(type_stop_out);
		if (source_impulse_out != 3'h0) begin
			last_op <= source_impulse_out;
		end
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task give_verdict;
		$display("Checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	task apply(input logic [18:0] p);
		@(posedge clk_in);
		setting <= p;
	endtask : apply

	// Waits for the next cycle decision; a mid-cycle panel change must not alter the running kind.
	task automatic next_boundary(input logic chk, input logic [6:0] held);
		int n;
		repeat (4) @(negedge clk_in);
		if (cycle_active_out === 1'b1) begin
			for (n = 0; n < 3000 && degree_out !== 9'h149; n++) @(negedge clk_in);
			if (chk) begin
				check("kind held", cycle_kind_out, held);
				check("point", point_out, 5'h12);
			end
			for (n = 0; n < 3000 && degree_out === 9'h149; n++) @(negedge clk_in);
		end
		repeat (3) @(negedge clk_in);
	endtask : next_boundary

	task automatic group_seq(input logic [1:0] d, output int pos);
		int g;
		int s0;
		pos = -1;
		g = -1;
		s0 = stop_cnt;
		apply(MOT | CRD | GRP | TOT | GCH | 19'(d));
		for (int i = 0; i < 8 && g < 0; i++) begin
			next_boundary(1'b0, 7'h00);
			if (cycle_kind_out === sequencer_pkg::CYC_PROG_TOTAL && pos < 0) begin
				pos = i;
				check("total speed", speed_out, 3'h2);
				check("total breakers", breakers_out, 3'h6);
				check("rotate", {counter_rotate_out, type_bars_active_out}, 2'h3);
				// The change is a level; leaving it up would open a new group after the total.
				apply(MOT | CRD | GRP | TOT | 19'(d));
			end
			if (cycle_kind_out === sequencer_pkg::CYC_GROUP_IND) begin
				g = i;
				check("indicate speed", speed_out, 3'h2);
				check("indicate breakers", breakers_out, 3'h7);
				check("print from card", print_from_card_out, 1'b1);
				apply(MOT | CRD | GRP | TOT | 19'(d));
			end
		end
		check("indicate after total", 16'(g - pos), 16'h0001);
		check("type stops", 16'(stop_cnt - s0), 16'h0008);
	endtask : group_seq

	initial begin
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		@(negedge clk_in);
		check("reset kind", cycle_kind_out, 7'h40);
		check("reset speed", speed_out, 3'h4);
		check("reset outputs", {breakers_out, clutches_out}, 8'h00);
		check("reset degree", degree_out, 9'h14A);
		check("reset point", point_out, 5'h12);
		apply(MOT);
		repeat (6) @(negedge clk_in);
		check("idling", {idling_out, cycle_active_out, clutches_out}, 7'h40);
		$display("Test reset and idling done");
		for (int i = 0; i < 8; i++) begin
			apply(rows[i].pnl);
			next_boundary(i > 0, rows[(i + 7) % 8].kind);
			check("kind", cycle_kind_out, rows[i].kind);
			check("speed", speed_out, rows[i].spd);
			check("breakers", breakers_out, rows[i].brk);
			check("picker", clutches_out.picker_knife_clutch, rows[i].fpi[2]);
			check("magnets", {clutches_out.high_speed_magnet, clutches_out.low_speed_magnet},
				(rows[i].spd == 3'h4) ? 2'h2 : 2'h1);
			check("feed print idle", {clutches_out.card_feed_clutch, clutches_out.print_clutch,
				idle_cycle_out}, rows[i].fpi);
			check("type bars", type_bars_active_out, rows[i].fpi[1]);
			if (rows[i].fpi[0]) begin
				check("high clutch", clutches_out.high_speed_magnet, 1'b1);
			end
			$display("Test row %0d done", i);
		end
		check("punch read", punch_done, 1'b1);
		group_seq(2'h0, p0);
		group_seq(2'h1, p1);
		check("total postponed", 16'(p1 - p0), 16'h0001);
		$display("Test group and totals done");
		@(posedge clk_in);
		ops <= 12'h8D1;
		apply(MOT | CRD | PEN);
		next_boundary(1'b0, 7'h00);
		next_boundary(1'b0, 7'h00);
		prev = last_op;
		for (int i = 0; i < 3; i++) begin
			next_boundary(1'b0, 7'h00);
			check("source impulse", last_op, (prev == 3'h4) ? 3'h1 : prev + 3'h1);
			prev = last_op;
		end
		$display("Test program steps done");
		apply(MOT | LST | CRD | MUL);
		next_boundary(1'b0, 7'h00);
		next_boundary(1'b0, 7'h00);
		check("multi line kind", cycle_kind_out, 7'h01);
		check("multi line feed", clutches_out.card_feed_clutch, 1'b1);
		check("multi line picker", clutches_out.picker_knife_clutch, 1'b0);
		$display("Test multiple line done");
		give_verdict();
	end

	// The run needs roughly twenty thousand clocks; a hang is cut off well beyond that.
	initial begin
		repeat (80000) @(posedge clk_in);
		fails++;
		give_verdict();
	end
endmodule : tb_machine_cycle_sequencer
`default_nettype wire
